// ### prioritized_interrupt_controller.sv
// interrupt controller: pending flags, enables, four-level priority, vectoring
`timescale 1ns/1ps
`include "irq_consts.svh"
module prioritized_interrupt_controller #(
  parameter int SAMPLE_DIV = `IRQ_SAMPLE_DIV
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // request pins, active low
  input wire logic ext_request_pin_a_in,
  input wire logic ext_request_pin_b_in,
  input wire logic [3:0] keyboard_request_lines_in,
  // internal peripheral request pulses or levels
  input wire logic tmr0_req_in,
  input wire logic tmr1_req_in,
  input wire logic serial_req_in,
  input wire logic decoder_req_in,
  input wire logic audio_req_in,
  input wire logic card_req_in,
  input wire logic two_wire_req_in,
  input wire logic spi_req_in,
  input wire logic conv_req_in,
  input wire logic usb_req_in,
  // software clear strobes for pending flags, one per polling position
  input wire logic [14:0] flag_clear_in,
  // configuration from the core
  input wire logic [7:0] enable_reg_first_in,
  input wire logic [7:0] enable_reg_second_in,
  input wire logic [7:0] prio_high_reg_first_in,
  input wire logic [7:0] prio_low_reg_first_in,
  input wire logic [7:0] prio_high_reg_second_in,
  input wire logic [7:0] prio_low_reg_second_in,
  input wire logic trigger_select_a_in,
  input wire logic trigger_select_b_in,
  // core handshake
  input wire logic instr_boundary_in,
  input wire logic vector_ack_in,
  input wire logic return_from_service_in,
  // to the core and the keyboard block
  output logic vector_req_out,
  output logic [15:0] vector_addr_out,
  output logic [14:0] pending_out,
  output logic [3:0] in_service_out,
  output logic [1:0] timer_control_reg_out,
  output logic [7:0] enable_reg_second_rd_out,
  output logic [3:0] keyboard_level_out,
  output logic wake_out
);
  localparam int N = `IRQ_NUM_POS;

  logic [2:0] div_q;
  logic sample_en_q;
  logic [5:0] sampled;
  logic ext_a_prev_q;
  logic ext_b_prev_q;
  logic [N-1:0] pend_q;
  logic [N-1:0] req_set;
  logic [N-1:0] hw_clr;
  logic [N-1:0] enabled;
  logic [N-1:0] prio_h;
  logic [N-1:0] prio_l;
  logic [3:0] in_service_q;
  irq_pkg::vec_state_e state_q;
  irq_pkg::pos_t win_pos;
  irq_pkg::level_t win_lvl;
  logic win_valid;
  irq_pkg::pos_t taken_pos_q;
  irq_pkg::level_t taken_lvl_q;

  function automatic logic [15:0] vec_of(input irq_pkg::pos_t p);
    vec_of = `IRQ_VEC_BASE + ({12'h000, p} * `IRQ_VEC_STEP);
  endfunction

  function automatic logic [3:0] lvl_hot(input irq_pkg::level_t l);
    lvl_hot = 4'h1 << l;
  endfunction

  // one-cycle sample strobe every peripheral cycle
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q <= 3'h0;
      sample_en_q <= 1'b0;
    end else begin
      sample_en_q <= (div_q == 3'(SAMPLE_DIV - 1));
      div_q <= (div_q == 3'(SAMPLE_DIV - 1)) ? 3'h0 : div_q + 3'h1;
    end
  end

  irq_pin_sampler #(.WIDTH(6)) u_sampler (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .pins_in({keyboard_request_lines_in, ext_request_pin_b_in, ext_request_pin_a_in}),
    .sample_en_in(sample_en_q),
    .sampled_out(sampled)
  );

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_a_prev_q <= 1'b1;
      ext_b_prev_q <= 1'b1;
    end else if (sample_en_q) begin
      ext_a_prev_q <= sampled[0];
      ext_b_prev_q <= sampled[1];
    end
  end

  // keyboard lines go to the keyboard block as sampled levels; no request comes back, so position 11 is never set
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      keyboard_level_out <= 4'hF;
      wake_out <= 1'b0;
    end else begin
      keyboard_level_out <= sampled[5:2];
      wake_out <= ~sampled[0] | ~sampled[1];
    end
  end

  // edge events are checked only on strobes, so a pulse shorter than a peripheral cycle may be lost
  always_comb begin
    req_set = '0;
    req_set[`IRQ_POS_EXT_A] = sample_en_q & (trigger_select_a_in ? (ext_a_prev_q & ~sampled[0])
                                                                 : ~sampled[0]);
    req_set[`IRQ_POS_EXT_B] = sample_en_q & (trigger_select_b_in ? (ext_b_prev_q & ~sampled[1])
                                                                 : ~sampled[1]);
    req_set[`IRQ_POS_TMR_0] = tmr0_req_in;
    req_set[`IRQ_POS_TMR_1] = tmr1_req_in;
    req_set[4] = serial_req_in;
    req_set[5] = decoder_req_in;
    req_set[6] = audio_req_in;
    req_set[7] = card_req_in;
    req_set[8] = two_wire_req_in;
    req_set[9] = spi_req_in;
    req_set[10] = conv_req_in;
    req_set[11] = 1'b0;
    req_set[13] = usb_req_in;
  end

  // hardware clear on vectoring for timers and edge-mode pins only
  always_comb begin
    hw_clr = '0;
    if (state_q == irq_pkg::ST_VECT && vector_ack_in) begin
      hw_clr[taken_pos_q] = (taken_pos_q == 4'(`IRQ_POS_TMR_0)) || (taken_pos_q == 4'(`IRQ_POS_TMR_1))
                         || (taken_pos_q == 4'(`IRQ_POS_EXT_A) && trigger_select_a_in)
                         || (taken_pos_q == 4'(`IRQ_POS_EXT_B) && trigger_select_b_in);
    end
  end

  // a new request in the clearing cycle keeps the flag set
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~(hw_clr | flag_clear_in)) | req_set;
      pend_q[`IRQ_POS_RSV_A] <= 1'b0;
      pend_q[`IRQ_POS_RSV_B] <= 1'b0;
    end
  end

  // keyboard request is tied low here; there is no keyboard block input, so position 11 never becomes pending
  logic kb_req;
  assign kb_req = 1'b0;

  always_comb begin
    enabled = '0;
    prio_h = '0;
    prio_l = '0;
    enabled[6:0] = enable_reg_first_in[6:0];
    enabled[11:7] = enable_reg_second_in[4:0];
    enabled[13] = enable_reg_second_in[6];
    if (!enable_reg_first_in[`IRQ_EN1_GLOBAL]) begin
      enabled = '0;
    end
    prio_h[6:0] = prio_high_reg_first_in[6:0];
    prio_l[6:0] = prio_low_reg_first_in[6:0];
    prio_h[11:7] = prio_high_reg_second_in[4:0];
    prio_l[11:7] = prio_low_reg_second_in[4:0];
    prio_h[13] = prio_high_reg_second_in[6];
    prio_l[13] = prio_low_reg_second_in[6];
  end

  // scan lowest position last so earlier positions win ties
  always_comb begin
    win_valid = 1'b0;
    win_pos = 4'h0;
    win_lvl = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_q[i] && enabled[i] && !(kb_req && i == 11)) begin
        if (!win_valid || {prio_h[i], prio_l[i]} >= win_lvl) begin
          win_valid = 1'b1;
          win_pos = 4'(i);
          win_lvl = {prio_h[i], prio_l[i]};
        end
      end
    end
    // only a strictly higher level than any in service may vector
    if (win_valid && |(in_service_q & ~(lvl_hot(win_lvl) - 4'h1) )) begin
      win_valid = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= irq_pkg::ST_IDLE;
      taken_pos_q <= 4'h0;
      taken_lvl_q <= 2'h0;
    end else begin
      case (state_q)
        irq_pkg::ST_IDLE: begin
          if (win_valid) begin
            state_q <= irq_pkg::ST_WAIT;
          end
        end
        irq_pkg::ST_WAIT: begin
          if (!win_valid) begin
            state_q <= irq_pkg::ST_IDLE;
          end else if (instr_boundary_in) begin
            state_q <= irq_pkg::ST_VECT;
            taken_pos_q <= win_pos;
            taken_lvl_q <= win_lvl;
          end
        end
        irq_pkg::ST_VECT: begin
          if (vector_ack_in) begin
            state_q <= irq_pkg::ST_IDLE;
          end
        end
        default: state_q <= irq_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vector_req_out <= 1'b0;
      vector_addr_out <= 16'h0000;
    end else begin
      vector_req_out <= (state_q == irq_pkg::ST_WAIT) && win_valid && instr_boundary_in;
      if (state_q == irq_pkg::ST_VECT && vector_ack_in) begin
        vector_req_out <= 1'b0;
      end else if (state_q == irq_pkg::ST_VECT) begin
        vector_req_out <= 1'b1;
      end
      if (state_q == irq_pkg::ST_WAIT && instr_boundary_in) begin
        vector_addr_out <= vec_of(win_pos);
      end
    end
  end

  // in-service markers: set on acknowledge, highest one dropped on return
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_service_q <= 4'h0;
    end else begin
      logic [3:0] nxt;
      nxt = in_service_q;
      if (return_from_service_in) begin
        for (int l = 0; l < 4; l++) begin
          if (in_service_q[l] && (in_service_q >> (l + 1)) == 4'h0) begin
            nxt[l] = 1'b0;
          end
        end
      end
      if (state_q == irq_pkg::ST_VECT && vector_ack_in) begin
        nxt = nxt | lvl_hot(taken_lvl_q);
      end
      in_service_q <= nxt;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pending_out <= '0;
      in_service_out <= 4'h0;
      timer_control_reg_out <= 2'h0;
      enable_reg_second_rd_out <= `IRQ_RESET_BYTE;
    end else begin
      pending_out <= pend_q;
      in_service_out <= in_service_q;
      timer_control_reg_out <= {pend_q[`IRQ_POS_EXT_B], pend_q[`IRQ_POS_EXT_A]};
      enable_reg_second_rd_out <= enable_reg_second_in & `IRQ_EN2_MASK;
    end
  end
endmodule // prioritized_interrupt_controller

// ### irq_consts.svh
// constants of the prioritized interrupt controller
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH
`define IRQ_NUM_POS 15
`define IRQ_VEC_BASE 16'h0003
`define IRQ_VEC_STEP 16'h0008
`define IRQ_SAMPLE_DIV 6
`define IRQ_POS_EXT_A 0
`define IRQ_POS_TMR_0 1
`define IRQ_POS_EXT_B 2
`define IRQ_POS_TMR_1 3
`define IRQ_POS_RSV_A 12
`define IRQ_POS_RSV_B 14
`define IRQ_EN1_GLOBAL 7
`define IRQ_EN2_MASK 8'h5F
`define IRQ_PRIO0_MASK 8'h7F
`define IRQ_PRIO1_MASK 8'h5F
`define IRQ_RESET_BYTE 8'h00
`endif

// ### irq_pkg.sv
// types of the prioritized interrupt controller
package irq_pkg;
  typedef logic [1:0] level_t;
  typedef logic [3:0] pos_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_VECT = 3'b100
  } vec_state_e;
endpackage

// ### irq_pin_sampler.sv
// synchronises request pins and samples them once per peripheral cycle
`timescale 1ns/1ps
`include "irq_consts.svh"
module irq_pin_sampler #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // pins and sample strobe
  input wire logic [WIDTH-1:0] pins_in,
  input wire logic sample_en_in,
  // sampled levels
  output logic [WIDTH-1:0] sampled_out
);
  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
    end
  end

  // idle-high reset value keeps reset from looking like a request
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sampled_out <= '1;
    end else if (sample_en_in) begin
      sampled_out <= sync2_q;
    end
  end
endmodule // irq_pin_sampler

// ### pic_sva.sv
// port assertions for the interrupt controller
`timescale 1ns/1ps
module pic_sva (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // watched inputs
  input wire logic tmr0_req_in,
  input wire logic [14:0] flag_clear_in,
  input wire logic [7:0] enable_reg_first_in,
  input wire logic vector_ack_in,
  input wire logic return_from_service_in,
  // watched outputs
  input wire logic vector_req_out,
  input wire logic [15:0] vector_addr_out,
  input wire logic [14:0] pending_out,
  input wire logic [3:0] in_service_out,
  input wire logic [7:0] enable_reg_second_rd_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence taken_s;
    vector_req_out && vector_ack_in;
  endsequence
  vec_hold_a: assert property (vector_req_out && !vector_ack_in |=> vector_req_out && $stable(vector_addr_out))
    else $error("vector dropped before acknowledge");
  vec_drop_a: assert property (taken_s |=> !vector_req_out)
    else $error("vector still raised after acknowledge");
  vec_addr_a: assert property (vector_req_out |-> vector_addr_out[2:0] == 3'h3 && vector_addr_out <= 16'h0073)
    else $error("vector address off the table");
  rsv_vec_a: assert property (vector_req_out |-> vector_addr_out != 16'h0063 && vector_addr_out != 16'h0073)
    else $error("reserved vector taken");
  glob_off_a: assert property ($rose(vector_req_out) |-> enable_reg_first_in[7])
    else $error("vector while globally masked");
  // marker and flag outputs are registered copies, so their effect shows two edges after the cause
  svc_mark_a: assert property (taken_s |-> ##2 in_service_out != 4'h0)
    else $error("no in-service mark after acknowledge");
  ret_clear_a: assert property (return_from_service_in && !vector_ack_in && $onehot(in_service_out)
    |-> ##2 in_service_out == 4'h0)
    else $error("return left in-service mark");
  tmr_hw_a: assert property (taken_s ##0 vector_addr_out == 16'h000B && !tmr0_req_in |-> ##2 !pending_out[1])
    else $error("timer flag not cleared on vectoring");
  sw_keep_a: assert property (taken_s ##0 vector_addr_out == 16'h0023 && !flag_clear_in[4] |-> ##2 pending_out[4])
    else $error("software flag cleared by hardware");
  en2_rsv_a: assert property (!enable_reg_second_rd_out[7] && !enable_reg_second_rd_out[5])
    else $error("reserved enable bits read as one");
endmodule // pic_sva
bind prioritized_interrupt_controller pic_sva chk (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .tmr0_req_in(tmr0_req_in),
  .flag_clear_in(flag_clear_in), .enable_reg_first_in(enable_reg_first_in), .vector_ack_in(vector_ack_in),
  .return_from_service_in(return_from_service_in), .vector_req_out(vector_req_out),
  .vector_addr_out(vector_addr_out), .pending_out(pending_out), .in_service_out(in_service_out),
  .enable_reg_second_rd_out(enable_reg_second_rd_out));

// ### pic_core_model.sv
// stand-in for the core: instruction boundaries and vector acknowledge
`timescale 1ns/1ps
module pic_core_model (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // behaviour select and request
  input wire logic slow_in,
  input wire logic vector_req_in,
  // to the controller
  output logic instr_boundary_out,
  output logic vector_ack_out
);
  logic [1:0] dly_q;
  // a slow core reaches a boundary only every fourth cycle, like long instructions
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dly_q <= 2'h0;
      instr_boundary_out <= 1'b0;
      vector_ack_out <= 1'b0;
    end else begin
      dly_q <= dly_q + 2'h1;
      instr_boundary_out <= !slow_in || dly_q == 2'h3;
      vector_ack_out <= vector_req_in && !vector_ack_out && (!slow_in || dly_q == 2'h1);
    end
  end
endmodule // pic_core_model

// ### prioritized_interrupt_controller_bench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module prioritized_interrupt_controller_bench;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic pin_a = 1'b1, pin_b = 1'b1, ta = 1'b0, tb = 1'b0, glob = 1'b1, ret = 1'b0, slow = 1'b0;
  logic [3:0] kb = 4'hF;
  logic [9:0] per = '0;
  logic [7:0] rsv = '0;
  logic [14:0] clr = '0, en = '0, ph = '0, pl = '0;
  logic brk, ack, vreq, wake, seen_q;
  logic [15:0] vaddr;
  logic [14:0] pend;
  logic [3:0] isrv, kbl;
  logic [1:0] timer_control_reg;
  logic [7:0] en2rd;
  logic [15:0] expq[$];
  int n_fail = 0, n_tests = 0, seed = 32'hcf52;
  int perpos[10] = '{1, 3, 4, 5, 6, 7, 8, 9, 10, 13};
  always #4 mclk_in = ~mclk_in;
  prioritized_interrupt_controller #(.SAMPLE_DIV(6)) uut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .ext_request_pin_a_in(pin_a), .ext_request_pin_b_in(pin_b), .keyboard_request_lines_in(kb),
    .tmr0_req_in(per[0]), .tmr1_req_in(per[1]), .serial_req_in(per[2]), .decoder_req_in(per[3]),
    .audio_req_in(per[4]), .card_req_in(per[5]), .two_wire_req_in(per[6]), .spi_req_in(per[7]),
    .conv_req_in(per[8]), .usb_req_in(per[9]), .flag_clear_in(clr),
    .enable_reg_first_in({glob, en[6:0]}), .enable_reg_second_in({rsv[0], en[13], rsv[1], en[11:7]}),
    .prio_high_reg_first_in({rsv[2], ph[6:0]}), .prio_low_reg_first_in({rsv[3], pl[6:0]}),
    .prio_high_reg_second_in({rsv[4], ph[13], rsv[5], ph[11:7]}),
    .prio_low_reg_second_in({rsv[6], pl[13], rsv[7], pl[11:7]}),
    .trigger_select_a_in(ta), .trigger_select_b_in(tb), .instr_boundary_in(brk), .vector_ack_in(ack),
    .return_from_service_in(ret), .vector_req_out(vreq), .vector_addr_out(vaddr), .pending_out(pend),
    .in_service_out(isrv), .timer_control_reg_out(timer_control_reg), .enable_reg_second_rd_out(en2rd),
    .keyboard_level_out(kbl), .wake_out(wake));
  pic_core_model core (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .slow_in(slow), .vector_req_in(vreq),
    .instr_boundary_out(brk), .vector_ack_out(ack));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // every new vector is matched against the oldest expected address
  always @(negedge mclk_in) begin
    seen_q <= rst_b_in && vreq;
    if (vreq && !seen_q) begin
      if (expq.size() == 0) check(vaddr, 16'hFFFF);
      else check(vaddr, expq.pop_front());
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic pulse(input int k);
    per[k] = 1'b1;
    tick(1);
    per = '0;
  endtask
  // level sources must let go of the pin before the flag is cleared
  task automatic serve(input bit do_ret);
    int i;
    logic [3:0] p;
    i = 0;
    while (!(ack && vreq) && i < 300) begin
      tick(1);
      i++;
    end
    if (i >= 300) begin
      n_fail++;
      end_of_test();
    end
    p = 4'((vaddr - 16'h0003) >> 3);
    tick(1);
    pin_b = 1'b1;
    tick(20);
    check(16'(pend[p]), 16'(!(p == 4'h1 || p == 4'h3 || (p == 4'h0 && ta) || (p == 4'h2 && tb))));
    clr[p] = 1'b1;
    tick(1);
    clr = '0;
    ret = do_ret;
    tick(1);
    ret = 1'b0;
  endtask
  task automatic round();
    logic [14:0] m, live;
    int best, bl, lv;
    m = '0;
    en = 15'($random(seed));
    ph = 15'($random(seed));
    pl = 15'($random(seed));
    // reserved bits are driven at random: they must neither read back nor steer anything
    rsv = 8'($random(seed));
    for (int k = 0; k < 10; k++) if (per[k] == 1'b0 && 1'($random(seed))) m[perpos[k]] = 1'b1;
    live = m & en & 15'h2FFF;
    tick(1);
    check(16'(en2rd), {9'h0, en[13], 1'b0, en[11:7]});
    while (live != '0) begin
      bl = -1;
      best = 0;
      for (int p = 0; p < 15; p++) begin
        lv = {ph[p], pl[p]};
        if (live[p] && lv > bl) begin
          bl = lv;
          best = p;
        end
      end
      expq.push_back(16'h0003 + 16'(best * 8));
      live[best] = 1'b0;
    end
    for (int k = 0; k < 10; k++) per[k] = m[perpos[k]];
    tick(1);
    per = '0;
    tick(1);
    check(16'(pend), 16'(m));
    while (expq.size() > 0) serve(1);
    tick(10);
    check(16'(pend), 16'(m & ~(en & 15'h2FFF)));
    clr = 15'h7FFF;
    tick(1);
    clr = '0;
  endtask
  initial begin
    tick(8);
    rst_b_in = 1'b1;
    tick(1);
    check({vreq, pend}, 16'h0);
    kb = 4'($random(seed));
    tick(14);
    check(16'(kbl), 16'(kb));
    for (int r = 0; r < 12; r++) begin
      slow = r[0];
      round();
    end
    en = 15'h2FFF;
    ph = 15'h0008;
    pl = 15'h0008;
    expq.push_back(16'h000B);
    pulse(0);
    serve(0);
    pulse(2);
    tick(20);
    expq.push_back(16'h001B);
    pulse(1);
    serve(1);
    tick(20);
    expq.push_back(16'h0023);
    ret = 1'b1;
    tick(1);
    ret = 1'b0;
    serve(1);
    glob = 1'b0;
    pulse(0);
    tick(20);
    expq.push_back(16'h000B);
    glob = 1'b1;
    serve(1);
    ta = 1'b1;
    expq.push_back(16'h0003);
    pin_a = 1'b0;
    tick(11);
    check(16'(wake), 16'h1);
    tick(1);
    pin_a = 1'b1;
    serve(1);
    check(16'(timer_control_reg), 16'h0);
    expq.push_back(16'h0013);
    pin_b = 1'b0;
    serve(1);
    tick(40);
    check(16'(expq.size()), 16'h0);
    end_of_test();
  end
endmodule // prioritized_interrupt_controller_bench
